/* level_sync.sv */
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stage1 <= '0;
            stage2 <= '0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;
endmodule // level_sync

/* spi_far_model.sv */
// behavioural spi shifter facing the priority block: busy for a short transfer
`timescale 1ns/10ps
module spi_far_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic spi_freeze,
    output logic spi_busy
);
    logic [3:0] cnt;
    assign spi_busy = cnt != 4'h0;
    always_ff @(posedge clk)
    begin
        if (srst)
            cnt <= 4'h0;
        else if (start)
            cnt <= 4'h8;
        else if (spi_busy && !spi_freeze)
            cnt <= cnt - 4'h1;
    end
endmodule // spi_far_model

/* spi_pri_pkg.sv */
// constants for the spi interrupt priority control register block
package spi_pri_pkg;
    localparam logic [15:0] PRI_CTRL_ADDR = 16'h103f;
    localparam logic [15:0] SUSP_STAT_ADDR = 16'h1040;
    localparam int TEST_BIT = 7;
    localparam int PRIORITY_BIT = 6;
    localparam int SUSPEND_EN_BIT = 5;
    localparam int STAT_SUSPEND_BIT = 3;
    localparam logic [7:0] PRI_CTRL_RESET = 8'h00;
    localparam logic [7:0] PRI_CTRL_WMASK = 8'he0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0]
    {
        ST_RUN = 3'b001,
        ST_DRAIN = 3'b010,
        ST_FROZEN = 3'b100
    } suspend_state_t;
endpackage

/* spi_priority_regs.sv */
// spi interrupt priority control register with emulator suspend handling
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module spi_priority_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic privilege_mode,
    input wire logic emu_suspend,
    input wire logic spi_busy,
    input wire logic spi_irq,
    output logic irq_level1,
    output logic irq_level2,
    output logic spi_freeze,
    output logic factory_test_bit
);
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] next_rdata;
    logic next_irq_level1;
    logic next_irq_level2;
    logic next_spi_freeze;
    logic next_factory_test_bit;
    logic susp;
    spi_pri_pkg::suspend_state_t state;
    spi_pri_pkg::suspend_state_t next_state;
    logic ctrl_wr_hit;
    logic ctrl_rd_hit;
    logic stat_rd_hit;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
        hit = (a == target);
    endfunction

    // status byte: one-hot suspend state in the low bits, synced halt above them
    function automatic logic [7:0] status_word(input logic halted, input logic [2:0] st);
        status_word = 8'h00;
        status_word[2:0] = st;
        status_word[spi_pri_pkg::STAT_SUSPEND_BIT] = halted;
    endfunction

    // the emulator halt comes from the debug pod, outside this clock
    level_sync #(
        .WIDTH(1)
    ) u_susp_sync (
        .clk(clk),
        .srst(srst),
        .async_in(emu_suspend),
        .sync_out(susp)
    );

    // address decode; a write outside privilege mode never reaches the register
    always_comb
    begin
        ctrl_wr_hit = wr && privilege_mode && hit(addr, spi_pri_pkg::PRI_CTRL_ADDR);
        ctrl_rd_hit = rd && hit(addr, spi_pri_pkg::PRI_CTRL_ADDR);
        stat_rd_hit = rd && hit(addr, spi_pri_pkg::SUSP_STAT_ADDR);
    end

    // register write and read path
    always_comb
    begin
        next_ctrl = ctrl;
        next_rdata = spi_pri_pkg::RDATA_IDLE;
        if (ctrl_wr_hit)
        begin
            next_ctrl = wdata & spi_pri_pkg::PRI_CTRL_WMASK;
        end
        if (ctrl_rd_hit)
        begin
            next_rdata = ctrl & spi_pri_pkg::PRI_CTRL_WMASK;
        end
        else if (stat_rd_hit)
        begin
            next_rdata = status_word(susp, state);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl <= spi_pri_pkg::PRI_CTRL_RESET;
            rdata <= spi_pri_pkg::RDATA_IDLE;
        end
        else
        begin
            ctrl <= next_ctrl;
            rdata <= next_rdata;
        end
    end

    // interrupt request routing
    always_comb
    begin
        next_irq_level1 = spi_irq && !ctrl[spi_pri_pkg::PRIORITY_BIT];
        next_irq_level2 = spi_irq && ctrl[spi_pri_pkg::PRIORITY_BIT];
        next_factory_test_bit = ctrl[spi_pri_pkg::TEST_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_level1 <= 1'b0;
            irq_level2 <= 1'b0;
            factory_test_bit <= 1'b0;
        end
        else
        begin
            irq_level1 <= next_irq_level1;
            irq_level2 <= next_irq_level2;
            factory_test_bit <= next_factory_test_bit;
        end
    end

    // emulator suspend sequencing
    always_comb
    begin
        next_state = state;
        unique case (state)
            spi_pri_pkg::ST_RUN:
            begin
                if (susp)
                begin
                    if (ctrl[spi_pri_pkg::SUSPEND_EN_BIT])
                    begin
                        next_state = spi_pri_pkg::ST_FROZEN;
                    end
                    else if (spi_busy)
                    begin
                        next_state = spi_pri_pkg::ST_DRAIN;
                    end
                    else
                    begin
                        next_state = spi_pri_pkg::ST_FROZEN;
                    end
                end
            end
            spi_pri_pkg::ST_DRAIN:
            begin
                if (!susp)
                begin
                    next_state = spi_pri_pkg::ST_RUN;
                end
                else if (ctrl[spi_pri_pkg::SUSPEND_EN_BIT] || !spi_busy)
                begin
                    next_state = spi_pri_pkg::ST_FROZEN;
                end
            end
            spi_pri_pkg::ST_FROZEN:
            begin
                if (!susp)
                begin
                    next_state = spi_pri_pkg::ST_RUN;
                end
            end
            default:
            begin
                next_state = spi_pri_pkg::ST_RUN;
            end
        endcase
        // freeze is registered from the next state so it rises together with the state
        next_spi_freeze = (next_state == spi_pri_pkg::ST_FROZEN);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= spi_pri_pkg::ST_RUN;
            spi_freeze <= 1'b0;
        end
        else
        begin
            state <= next_state;
            spi_freeze <= next_spi_freeze;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // register bus checks
    chk_write_blocked: assert property (
        wr && !privilege_mode |=> $stable(ctrl))
        else $error("write outside privilege mode changed the register");

    chk_write_taken: assert property (
        wr && privilege_mode && addr == spi_pri_pkg::PRI_CTRL_ADDR
        |=> ctrl == ($past(wdata) & spi_pri_pkg::PRI_CTRL_WMASK))
        else $error("privileged write not stored");

    chk_read_value: assert property (
        rd && addr == spi_pri_pkg::PRI_CTRL_ADDR |=> rdata == $past(ctrl))
        else $error("read data does not match register");

    chk_read_one_cycle: assert property (
        !rd |=> rdata == spi_pri_pkg::RDATA_IDLE)
        else $error("read data present without a read");

    chk_reserved_zero: assert property (
        rd && addr == spi_pri_pkg::PRI_CTRL_ADDR |=> rdata[4:0] == 5'h00)
        else $error("reserved bits read back nonzero");

    chk_unmapped_read: assert property (
        rd && addr != spi_pri_pkg::PRI_CTRL_ADDR && addr != spi_pri_pkg::SUSP_STAT_ADDR
        |=> rdata == spi_pri_pkg::RDATA_IDLE)
        else $error("unmapped read returned data");

    chk_status_read: assert property (
        rd && addr == spi_pri_pkg::SUSP_STAT_ADDR |=> rdata == {4'h0, $past(susp), $past(state)})
        else $error("status read does not match suspend state");

    chk_other_write: assert property (
        wr && addr != spi_pri_pkg::PRI_CTRL_ADDR |=> $stable(ctrl))
        else $error("write to another address changed the register");

    chk_reset_clears: assert property (
        @(posedge clk) disable iff (1'b0)
        srst |=> ctrl == spi_pri_pkg::PRI_CTRL_RESET && rdata == spi_pri_pkg::RDATA_IDLE
            && !spi_freeze && !factory_test_bit && !irq_level1 && !irq_level2)
        else $error("reset did not clear the register and outputs");

    chk_test_clear: assert property (
        !ctrl[spi_pri_pkg::TEST_BIT] |=> !factory_test_bit)
        else $error("test bit output set while the register bit is clear");

    // interrupt routing checks
    sequence req_high_pri;
        spi_irq && !ctrl[spi_pri_pkg::PRIORITY_BIT];
    endsequence

    chk_irq_level_one: assert property (
        req_high_pri |=> irq_level1 && !irq_level2)
        else $error("high priority request misrouted");

    chk_irq_level_two: assert property (
        spi_irq && ctrl[spi_pri_pkg::PRIORITY_BIT] |=> irq_level2 && !irq_level1)
        else $error("low priority request misrouted");

    chk_irq_exclusive: assert property (
        !(irq_level1 && irq_level2))
        else $error("both request levels raised at once");

    chk_irq_idle: assert property (
        !spi_irq |=> !irq_level1 && !irq_level2)
        else $error("request raised without an spi interrupt");

    // emulator suspend checks
    chk_no_halt_run: assert property (
        !susp |=> !spi_freeze)
        else $error("freeze without emulator suspend");

    chk_drain_first: assert property (
        susp && !ctrl[spi_pri_pkg::SUSPEND_EN_BIT] && spi_busy && !spi_freeze
        |=> !spi_freeze)
        else $error("froze before transfer completed");

    chk_freeze_now: assert property (
        susp && ctrl[spi_pri_pkg::SUSPEND_EN_BIT] |=> spi_freeze)
        else $error("suspend enable did not freeze at once");

    chk_drain_ends: assert property (
        susp && !spi_busy ##1 susp |-> ##1 spi_freeze)
        else $error("idle spi not frozen under suspend");

    chk_state_onehot: assert property (
        $onehot(state))
        else $error("suspend state left its one-hot codes");

    chk_frozen_holds: assert property (
        spi_freeze && susp |=> spi_freeze)
        else $error("freeze released while the emulator still halts");

    chk_freeze_cause: assert property (
        $rose(spi_freeze) |-> $past(ctrl[spi_pri_pkg::SUSPEND_EN_BIT]) || !$past(spi_busy))
        else $error("froze with a transfer running and suspend enable clear");

    chk_resume_run: assert property (
        !susp |=> state == spi_pri_pkg::ST_RUN)
        else $error("suspend state kept without emulator halt");

    chk_drain_waits: assert property (
        state == spi_pri_pkg::ST_DRAIN && susp && !ctrl[spi_pri_pkg::SUSPEND_EN_BIT] && spi_busy
        |=> state == spi_pri_pkg::ST_DRAIN)
        else $error("drain left before the transfer completed");

    // main scenarios
    cov_priv_write: cover property (
        wr && privilege_mode && addr == spi_pri_pkg::PRI_CTRL_ADDR);
    cov_drain_freeze: cover property (
        state == spi_pri_pkg::ST_DRAIN ##1 state == spi_pri_pkg::ST_FROZEN);
    cov_level_two: cover property (irq_level2);
    cov_resume: cover property (spi_freeze ##1 !spi_freeze);
    cov_freeze_now: cover property (susp && ctrl[spi_pri_pkg::SUSPEND_EN_BIT] && spi_busy ##1 spi_freeze);
endmodule // spi_priority_regs

/* spi_priority_regs_test.sv */
// self-checking bench for the spi interrupt priority register block
`timescale 1ns/10ps
module spi_priority_regs_test;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, privilege_mode = 1'b0;
    logic emu_suspend = 1'b0, spi_irq = 1'b0, start = 1'b0, p;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, exp_reg = 8'h00, d, rdata;
    logic irq_level1, irq_level2, spi_freeze, factory_test_bit, spi_busy;
    int bad_count = 0, check_count = 0, n;
    initial forever #2 clk = ~clk;
    spi_priority_regs spi_priority_regs_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .privilege_mode(privilege_mode), .emu_suspend(emu_suspend), .spi_busy(spi_busy),
        .spi_irq(spi_irq), .irq_level1(irq_level1), .irq_level2(irq_level2), .spi_freeze(spi_freeze),
        .factory_test_bit(factory_test_bit));
    spi_far_model spi_far_model_i (.clk(clk), .srst(srst), .start(start), .spi_freeze(spi_freeze),
        .spi_busy(spi_busy));
    function automatic logic [7:0] next_exp(input logic [7:0] old, input logic [7:0] v, input logic pr);
        return pr ? (v & spi_pri_pkg::PRI_CTRL_WMASK) : old;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic write(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic read(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check("rdata", rdata, exp);
    endtask
    task automatic wait_freeze(input logic lvl, input int lim);
        n = 0;
        while (spi_freeze !== lvl && n < lim)
        begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    // bit 5 decides whether a running transfer drains before the freeze
    task automatic suspend_case(input logic [7:0] v);
        write(spi_pri_pkg::PRI_CTRL_ADDR, v);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        emu_suspend <= 1'b1;
        wait_freeze(1'b1, 30);
        check("freeze", {7'h00, spi_freeze}, 8'h01);
        check("busy at freeze", {7'h00, spi_busy}, {7'h00, v[5]});
        read(spi_pri_pkg::SUSP_STAT_ADDR, 8'h0c);
        @(posedge clk);
        emu_suspend <= 1'b0;
        wait_freeze(1'b0, 8);
        check("release", {7'h00, spi_freeze}, 8'h00);
        $display("test suspend %h done", v);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(48497));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        read(spi_pri_pkg::PRI_CTRL_ADDR, spi_pri_pkg::PRI_CTRL_RESET);
        check("test bit", {7'h00, factory_test_bit}, 8'h00);
        read(spi_pri_pkg::SUSP_STAT_ADDR, 8'h01);
        $display("test reset done");
        for (int i = 0; i < 24; i++)
        begin
            d = (i < 2) ? 8'hff : 8'($urandom);
            p = (i == 1) || (i > 1 && $urandom_range(1) == 1);
            if (p)
                d[spi_pri_pkg::TEST_BIT] = 1'b0;
            @(posedge clk);
            privilege_mode <= p;
            write(spi_pri_pkg::PRI_CTRL_ADDR, d);
            exp_reg = next_exp(exp_reg, d, p);
            read(spi_pri_pkg::PRI_CTRL_ADDR, exp_reg);
            read({4'h2, 12'($urandom)}, 8'h00);
            check("test bit", {7'h00, factory_test_bit}, {7'h00, exp_reg[7]});
            @(posedge clk);
            spi_irq <= 1'($urandom_range(1));
            @(posedge clk);
            #1 check("levels", {6'h00, irq_level1, irq_level2}, {6'h00, spi_irq & ~exp_reg[6], spi_irq & exp_reg[6]});
            check("idle freeze", {7'h00, spi_freeze}, 8'h00);
        end
        $display("test register and routing done");
        @(posedge clk);
        privilege_mode <= 1'b1;
        suspend_case(8'h20);
        suspend_case(8'h00);
        results();
    end
    initial
    begin
        #40000;
        bad_count++;
        $display("watchdog expired");
        results();
    end
endmodule // spi_priority_regs_test
